// ==== hdl/tmt_clkout.v ====
`timescale 1ns/1ns
// toggle stage turning counter wraps into a square wave
module tmt_clkout (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire enable,
	input wire wrapPulse,
	output reg clockOut
);
	// one toggle per wrap halves the wrap rate, even duty
	always @(posedge clk) begin
		if (sys_rst) begin
			clockOut <= 1'b0;
		end else if (ce) begin
			if (!enable) begin
				// parked low while the feature is off
				clockOut <= 1'b0;
			end else if (wrapPulse) begin
				clockOut <= ~clockOut;
			end
		end
	end
endmodule // tmt_clkout

// ==== hdl/tmt_edge_det.v ====
`timescale 1ns/1ns
// falling edge detectors for the synchronous pin inputs
module tmt_edge_det #(
	parameter WIDTH = 2
) (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire [WIDTH-1:0] pinIn,
	output wire [WIDTH-1:0] pinFall
);
	// last sampled level, idles high like a pulled-up pin
	reg [WIDTH-1:0] pinLast;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// remember previous level per pin
			always @(posedge clk) begin
				if (sys_rst) begin
					pinLast[i] <= 1'b1;
				end else if (ce) begin
					pinLast[i] <= pinIn[i];
				end
			end
			// one-cycle pulse on a high-to-low step
			assign pinFall[i] = ce & pinLast[i] & ~pinIn[i];
		end
	endgenerate
endmodule // tmt_edge_det

// ==== hdl/tmt_top.v ====
`timescale 1ns/1ns
`include "tmt_defs.vh"
// sixteen-bit timer with reload, capture, baud and clock-out
module tmt_top (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// count clock pin, three-signal form
	input wire countPinIn,
	output wire countPinOut,
	output wire countPinOe,
	// external trigger pin
	input wire triggerPinIn,
	// serial port clocking
	input wire timerOneOvf,
	output reg rxBaudTick,
	output reg txBaudTick,
	// timer interrupt request level
	output wire timerIrq
);

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	reg [7:0] timer_two_control; // control and flags
	reg [7:0] timer_two_mode_reg; // clock-out and up/down enables
	reg [15:0] reloadWord; // reload_high_byte:reload_low_byte
	reg [15:0] countWord; // count_high_byte:count_low_byte
	reg [3:0] presc; // prescaler phase
	reg readLoaded; // prdata holds the addressed register

	// next values
	reg [7:0] next_control;
	reg [15:0] next_count;
	reg [15:0] next_reload;

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	wire overflow_flag = timer_two_control[`TMT_OVF_BIT];
	wire external_event_flag = timer_two_control[`TMT_EXT_BIT];
	wire rx_clock_source = timer_two_control[`TMT_RXSRC_BIT];
	wire tx_clock_source = timer_two_control[`TMT_TXSRC_BIT];
	wire external_edge_enable = timer_two_control[`TMT_EXEN_BIT];
	wire run_control = timer_two_control[`TMT_RUN_BIT];
	wire count_source_select = timer_two_control[`TMT_CNTSEL_BIT];
	wire capture_reload_select = timer_two_control[`TMT_CAPSEL_BIT];
	wire clock_out_enable = timer_two_mode_reg[`TMT_CLKOE_BIT];
	wire updown_enable = timer_two_mode_reg[`TMT_UPDN_BIT];

	// either baud source on means the timer clocks the serial port
	wire baudMode = rx_clock_source | tx_clock_source;
	// clock-out and baud run the fast prescaler
	wire fastMode = clock_out_enable | baudMode;
	// up/down counting only in plain auto-reload mode
	wire upDownMode = updown_enable & ~capture_reload_select & ~baudMode;

	// ------------------------------------------------------------
	// pin edge detection
	// ------------------------------------------------------------
	wire countFall; // falling edge on the count pin
	wire trigFall; // falling edge on the trigger pin

	tmt_edge_det #(
		.WIDTH(2)
	) u_edges (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.pinIn({triggerPinIn, countPinIn}),
		.pinFall({trigFall, countFall})
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire hitCtrl = (paddr == `TMT_CTRL_OFS);
	wire hitMode = (paddr == `TMT_MODE_OFS);
	wire hitRldLo = (paddr == `TMT_RLD_LO_OFS);
	wire hitRldHi = (paddr == `TMT_RLD_HI_OFS);
	wire hitCntLo = (paddr == `TMT_CNT_LO_OFS);
	wire hitCntHi = (paddr == `TMT_CNT_HI_OFS);
	wire hitAny = hitCtrl | hitMode | hitRldLo | hitRldHi | hitCntLo | hitCntHi;

	// ready once the read data was staged, and never while frozen
	assign pready = ce & readLoaded;
	// unmapped addresses answer with an error
	assign pslverr = psel & penable & pready & ~hitAny;

	// a write lands at the completing access edge only
	wire wrEn = psel & penable & pwrite & pready;
	wire wrCtrl = wrEn & hitCtrl;
	wire wrMode = wrEn & hitMode;
	wire wrRldLo = wrEn & hitRldLo;
	wire wrRldHi = wrEn & hitRldHi;
	wire wrCntLo = wrEn & hitCntLo;
	wire wrCntHi = wrEn & hitCntHi;

	// read mux of register contents
	reg [31:0] readMux;
	always @* begin
		readMux = 32'h0000_0000;
		case (1'b1)
			hitCtrl: begin
				readMux[7:0] = timer_two_control;
			end
			hitMode: begin
				readMux[7:0] = timer_two_mode_reg;
			end
			hitRldLo: begin
				readMux[7:0] = reloadWord[7:0];
			end
			hitRldHi: begin
				readMux[7:0] = reloadWord[15:8];
			end
			hitCntLo: begin
				readMux[7:0] = countWord[7:0];
			end
			hitCntHi: begin
				readMux[7:0] = countWord[15:8];
			end
			default: begin
				// unmapped reads as zero
				readMux = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------
	// prescaler and count source
	// ------------------------------------------------------------
	wire [3:0] divSel = fastMode ? `TMT_FAST_DIV : `TMT_SLOW_DIV;
	// prescaler only advances while running
	wire presTick = run_control & (presc == (divSel - 4'h1));
	// clock-out does not force count_source_select clear; with it clear the internal tick is at clk/2
	wire countTick = count_source_select ? (run_control & countFall) : presTick;

	// ------------------------------------------------------------
	// wrap detection
	// ------------------------------------------------------------
	// trigger pin sets direction in up/down mode, high counts up
	wire dirUp = ~upDownMode | triggerPinIn;
	wire ovfUp = countTick & dirUp & (countWord == `TMT_CNT_MAX);
	wire undDown = countTick & ~dirUp & (countWord == reloadWord);
	wire wrapEvt = ovfUp | undDown;
	// baud mode forces auto-reload over capture select
	wire reloadOnOvf = ~capture_reload_select | baudMode;

	// trigger edges count only when enabled and not clocking the uart
	wire trigEvt = trigFall & external_edge_enable & ~baudMode & ~upDownMode;
	wire trigCapture = trigEvt & capture_reload_select;
	wire trigReload = trigEvt & ~capture_reload_select;

	// flag sources
	// overflow flag only outside baud mode, never in clock-out mode
	wire ovfSet = wrapEvt & ~baudMode & ~clock_out_enable;
	wire extSet = trigEvt;

	// ------------------------------------------------------------
	// next control value: software write, then hardware sets win
	// ------------------------------------------------------------
	always @* begin
		next_control = timer_two_control;
		if (wrCtrl) begin
			// every bit writable, flags cleared only by writing zero
			next_control = pwdata[7:0];
		end
		if (ovfSet) begin
			next_control[`TMT_OVF_BIT] = 1'b1;
		end
		if (extSet) begin
			next_control[`TMT_EXT_BIT] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// next count and reload values
	// ------------------------------------------------------------
	always @* begin
		next_count = countWord;
		next_reload = reloadWord;
		if (ovfUp) begin
			// wrap up: reload or roll to zero in capture mode
			next_count = reloadOnOvf ? reloadWord : 16'h0000;
		end else if (undDown) begin
			// wrap down: restart from the top
			next_count = `TMT_CNT_MAX;
		end else if (countTick) begin
			// plain step in the chosen direction
			next_count = dirUp ? (countWord + 16'h0001) : (countWord - 16'h0001);
		end
		if (trigReload) begin
			// trigger edge reloads the counter
			next_count = reloadWord;
		end
		if (trigCapture) begin
			// trigger edge captures the running count
			next_reload = countWord;
		end
		// software byte writes take priority over counting
		if (wrCntLo) begin
			next_count[7:0] = pwdata[7:0];
		end
		if (wrCntHi) begin
			next_count[15:8] = pwdata[7:0];
		end
		if (wrRldLo) begin
			next_reload[7:0] = pwdata[7:0];
		end
		if (wrRldHi) begin
			next_reload[15:8] = pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			timer_two_control <= `TMT_CTRL_RST;
			timer_two_mode_reg <= `TMT_MODE_RST;
			reloadWord <= `TMT_WORD_RST;
			countWord <= `TMT_WORD_RST;
			presc <= 4'h0;
		end else if (ce) begin
			timer_two_control <= next_control;
			countWord <= next_count;
			reloadWord <= next_reload;
			if (wrMode) begin
				// only the two mode bits are stored
				timer_two_mode_reg <= pwdata[7:0] & 8'h03;
			end
			if (!run_control) begin
				// stopped: prescaler restarts from zero
				presc <= 4'h0;
			end else if (presTick) begin
				presc <= 4'h0;
			end else begin
				presc <= presc + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// apb read staging
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			readLoaded <= 1'b0;
		end else if (ce) begin
			if (psel) begin
				// refreshed every cycle of the transfer
				prdata <= readMux;
				readLoaded <= ~(penable & readLoaded);
			end else begin
				readLoaded <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// serial port baud clock selection
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (sys_rst) begin
			rxBaudTick <= 1'b0;
			txBaudTick <= 1'b0;
		end else if (ce) begin
			// receive side
			rxBaudTick <= rx_clock_source ? wrapEvt : timerOneOvf;
			// transmit side
			txBaudTick <= tx_clock_source ? wrapEvt : timerOneOvf;
		end
		if (sys_rst) begin
			rxBaudTick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// clock-out generator on the count pin
	// ------------------------------------------------------------
	wire clockOutLevel;

	tmt_clkout u_clkout (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.enable(clock_out_enable),
		.wrapPulse(wrapEvt),
		.clockOut(clockOutLevel)
	);

	// pin driven only in clock-out mode
	assign countPinOut = clockOutLevel;
	assign countPinOe = clock_out_enable;

	// ------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------
	// external flag is masked whenever the up/down enable bit is set, in any mode
	assign timerIrq = overflow_flag | (external_event_flag & ~updown_enable);

endmodule // tmt_top

// ==== shared/tmt_defs.vh ====
`ifndef TMT_DEFS_VH
`define TMT_DEFS_VH

// register byte offsets on the apb bus
`define TMT_CTRL_OFS 8'hc8
`define TMT_MODE_OFS 8'hcc
`define TMT_RLD_LO_OFS 8'hd0
`define TMT_RLD_HI_OFS 8'hd4
`define TMT_CNT_LO_OFS 8'hd8
`define TMT_CNT_HI_OFS 8'hdc

// control register bit positions
`define TMT_OVF_BIT 7
`define TMT_EXT_BIT 6
`define TMT_RXSRC_BIT 5
`define TMT_TXSRC_BIT 4
`define TMT_EXEN_BIT 3
`define TMT_RUN_BIT 2
`define TMT_CNTSEL_BIT 1
`define TMT_CAPSEL_BIT 0

// mode register bit positions
`define TMT_CLKOE_BIT 1
`define TMT_UPDN_BIT 0

// reset values
`define TMT_CTRL_RST 8'h00
`define TMT_MODE_RST 8'h00
`define TMT_WORD_RST 16'h0000

// counter limits
`define TMT_CNT_MAX 16'hffff

// prescaler divisors: fast for clock-out and baud, slow otherwise
`define TMT_FAST_DIV 4'h2
`define TMT_SLOW_DIV 4'hc

`endif

// ==== sim/tmt_chk.sv ====
`timescale 1ns/1ns
`include "tmt_defs.vh"
// watches the timer ports against a shadow of the written setup
module tmt_chk (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire countPinIn,
	input wire countPinOut,
	input wire countPinOe,
	input wire triggerPinIn,
	input wire timerOneOvf,
	input wire rxBaudTick,
	input wire txBaudTick,
	input wire timerIrq
);
	reg [7:0] shCtrl; // shadow of control byte
	reg [1:0] shMode; // shadow of mode bits
	reg prevOut; // last clock-out level
	wire done = psel && penable && pready; // completed transfer
	wire wr = done && pwrite; // completed write
	wire mapped = paddr >= 8'hc8 && paddr <= 8'hdc && paddr[1:0] == 2'h0; // six word slots
	wire tog = countPinOut != prevOut; // clock-out edge seen
	reg [15:0] span; // cycles since last edge
	reg [15:0] lastSpan; // previous edge spacing
	reg [1:0] good; // edges since last write to any register
	// shadow of setup bits and edge spacing
	always @(posedge clk) begin
		if (sys_rst) begin
			shCtrl <= 8'h00;
			shMode <= 2'h0;
			prevOut <= 1'b0;
			span <= 16'h0000;
			lastSpan <= 16'h0000;
			good <= 2'h0;
		end else begin
			prevOut <= countPinOut;
			if (wr && paddr == `TMT_CTRL_OFS)
				shCtrl <= pwdata[7:0];
			if (wr && paddr == `TMT_MODE_OFS)
				shMode <= pwdata[1:0];
			if (tog) begin
				span <= 16'h0001;
				lastSpan <= span;
			end else
				span <= span + 16'h0001;
			if (wr)
				good <= 2'h0;
			else if (tog && good != 2'h2)
				good <= good + 2'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_ZERO_WAIT: assert property (psel && !penable && ce ##1 psel && penable && ce |-> pready)
		else $error("pready late after setup");
	AST_UNMAPPED_ERR: assert property (done |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	AST_OE_MODE: assert property (countPinOe == shMode[1])
		else $error("count pin enable not following mode");
	AST_NO_OVF_IRQ: assert property (shMode[1] && !shCtrl[3] |-> !$rose(timerIrq))
		else $error("irq raised in clock-out mode");
	AST_CLKOUT_EVEN: assert property (tog && good == 2'h2 |-> span == lastSpan)
		else $error("clock-out halves differ");
	AST_STOP_HOLD: assert property ((!shCtrl[2] && shMode[1]) [*3] |-> $stable(countPinOut))
		else $error("clock-out moved while stopped");
	AST_RX_T1: assert property (!shCtrl[5] && ce && !sys_rst |=> rxBaudTick == $past(timerOneOvf))
		else $error("receive tick not from timer one");
	AST_TX_T1: assert property (!shCtrl[4] && ce && !sys_rst |=> txBaudTick == $past(timerOneOvf))
		else $error("transmit tick not from timer one");
	AST_FLAG_SW: assert property ($fell(timerIrq) |-> $past(wr && paddr >= 8'hc8 && paddr <= 8'hcc))
		else $error("flag cleared without a write");
	cover property (tog && good == 2'h2);
	cover property ($rose(timerIrq));
	cover property (done && !mapped);
endmodule // tmt_chk

bind tmt_top tmt_chk tmt_chk_i (.clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .countPinIn(countPinIn), .countPinOut(countPinOut),
	.countPinOe(countPinOe), .triggerPinIn(triggerPinIn), .timerOneOvf(timerOneOvf),
	.rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .timerIrq(timerIrq));

// ==== sim/tmt_pins.sv ====
`timescale 1ns/1ns
// outside world of the count and trigger pins
module tmt_pins (
	input wire clk,
	input wire countPinOut,
	input wire countPinOe,
	output wire countPinIn,
	output logic triggerPinIn
);
	logic extLevel = 1'b1; // outside driver, released to pull-up level
	// pin level: the timer owns it while clock-out is enabled
	assign countPinIn = countPinOe ? countPinOut : extLevel;
	initial triggerPinIn = 1'b1;
	// slow falling edges on the count pin
	task fallEdges(input int k);
		repeat (k) begin
			@(posedge clk);
			extLevel <= 1'b0;
			repeat (3) @(posedge clk);
			extLevel <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	// one falling edge on the trigger pin
	task trigFall();
		@(posedge clk);
		triggerPinIn <= 1'b0;
		repeat (3) @(posedge clk);
		triggerPinIn <= 1'b1;
		@(posedge clk);
	endtask
endmodule // tmt_pins

// ==== sim/tmt_top_bench.sv ====
`timescale 1ns/1ns
`include "tmt_defs.vh"
// self-checking bench for the timer block
module tmt_top_bench;
	logic clk, sys_rst, psel, penable, pwrite, timerOneOvf;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	wire [31:0] prdata;
	wire pready, pslverr, countPinIn, countPinOut, countPinOe, triggerPinIn;
	wire rxBaudTick, txBaudTick, timerIrq;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] expQ[$]; // expected read bytes
	logic [31:0] seed = 32'd76934; // xorshift state
	int n, r;
	tmt_top tmt_top_i (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .countPinIn(countPinIn), .countPinOut(countPinOut),
		.countPinOe(countPinOe), .triggerPinIn(triggerPinIn), .timerOneOvf(timerOneOvf),
		.rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .timerIrq(timerIrq));
	tmt_pins tmt_pins_i (.clk(clk), .countPinOut(countPinOut), .countPinOe(countPinOe),
		.countPinIn(countPinIn), .triggerPinIn(triggerPinIn));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task check(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done();
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one apb transfer; a read notes its expected byte
	task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		// look at pready where it is settled, complete at the next edge
		@(negedge clk);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(negedge clk);
		end
		if (k == 50) begin
			fail_count++;
			test_done();
		end
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		apb(a, 1'b0, 8'h00);
	endtask
	task irq(input logic e);
		@(negedge clk);
		check("timerIrq", {31'h0, e}, {31'h0, timerIrq});
	endtask
	// cycles until the clock-out level changes
	task waitTog(input int lim, output int k);
		logic v;
		v = countPinOut;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (countPinOut === v && k < lim);
	endtask
	// compares each completed read with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			if (expQ.size() == 0)
				check("read note", 32'h1, 32'h0);
			else
				check("prdata", {24'h000000, expQ.pop_front()}, prdata);
		end
	end
	// random timer one overflow pulses
	always @(posedge clk) begin
		timerOneOvf <= ^rnd();
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		timerOneOvf = 1'b0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`TMT_CTRL_OFS, 8'h00);
		rd(8'he0, 8'h00);
		// plain timer overflow sets the flag
		wr(`TMT_CNT_LO_OFS, 8'hff);
		wr(`TMT_CNT_HI_OFS, 8'hff);
		wr(`TMT_CTRL_OFS, 8'h04);
		repeat (30) @(posedge clk);
		irq(1'b1);
		rd(`TMT_CTRL_OFS, 8'h84);
		// baud source: overflows leave the flag clear
		wr(`TMT_CTRL_OFS, 8'h00);
		wr(`TMT_RLD_LO_OFS, 8'hf0);
		wr(`TMT_RLD_HI_OFS, 8'hff);
		wr(`TMT_CNT_LO_OFS, 8'hf0);
		wr(`TMT_CNT_HI_OFS, 8'hff);
		wr(`TMT_CTRL_OFS, 8'h34);
		repeat (100) @(posedge clk);
		rd(`TMT_CTRL_OFS, 8'h34);
		// capture on trigger, refused while edges are off
		wr(`TMT_CTRL_OFS, 8'h01);
		wr(`TMT_CNT_LO_OFS, 8'h34);
		wr(`TMT_CNT_HI_OFS, 8'h12);
		tmt_pins_i.trigFall();
		rd(`TMT_CTRL_OFS, 8'h01);
		rd(`TMT_RLD_LO_OFS, 8'hf0);
		wr(`TMT_CTRL_OFS, 8'h09);
		tmt_pins_i.trigFall();
		rd(`TMT_CTRL_OFS, 8'h49);
		rd(`TMT_RLD_LO_OFS, 8'h34);
		rd(`TMT_RLD_HI_OFS, 8'h12);
		irq(1'b1);
		wr(`TMT_MODE_OFS, 8'h01);
		irq(1'b0);
		// reload on trigger
		wr(`TMT_MODE_OFS, 8'h00);
		wr(`TMT_CTRL_OFS, 8'h08);
		wr(`TMT_CNT_LO_OFS, 8'h00);
		tmt_pins_i.trigFall();
		rd(`TMT_CTRL_OFS, 8'h48);
		rd(`TMT_CNT_LO_OFS, 8'h34);
		// counting count pin falling edges
		r = int'(rnd() & 32'h7) + 1;
		wr(`TMT_CTRL_OFS, 8'h06);
		wr(`TMT_CNT_LO_OFS, 8'h00);
		tmt_pins_i.fallEdges(r);
		rd(`TMT_CNT_LO_OFS, r[7:0]);
		// clock-out at a random reload
		r = int'(rnd() & 32'h3f);
		wr(`TMT_CTRL_OFS, 8'h00);
		wr(`TMT_MODE_OFS, 8'h02);
		wr(`TMT_RLD_LO_OFS, 8'hc0 | r[7:0]);
		wr(`TMT_RLD_HI_OFS, 8'hff);
		wr(`TMT_CNT_LO_OFS, 8'hc0 | r[7:0]);
		wr(`TMT_CNT_HI_OFS, 8'hff);
		wr(`TMT_CTRL_OFS, 8'h04);
		waitTog(1000, n);
		waitTog(1000, n);
		check("half period", 2 * (64 - r), n);
		waitTog(1000, n);
		check("half period", 2 * (64 - r), n);
		rd(`TMT_CTRL_OFS, 8'h04);
		wr(`TMT_CTRL_OFS, 8'h00);
		repeat (2) @(posedge clk);
		waitTog(300, n);
		check("stopped", 300, n);
		test_done();
	end
endmodule // tmt_top_bench
